// [rtl/svlr_pkg.sv]
package svlr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame: start, payload, balance, spare, stop (first bit on top)
  localparam int FRAME_BITS   = 28;
  localparam int PAYLOAD_BITS = 24;
  localparam int START_POS    = 27;
  localparam int PAYLOAD_LSB  = 3;
  localparam int BALANCE_POS  = 2;
  localparam int SPARE_POS    = 1;
  localparam int STOP_POS     = 0;

  // payload fields
  localparam int COLOUR_BITS = 18;
  localparam int COLOUR_LSB  = 0;
  localparam int HSYNC_POS   = 18;
  localparam int VSYNC_POS   = 19;
  localparam int ENABLE_POS  = 20;
  localparam int SLOW_LSB    = 21;
  localparam int SLOW_BITS   = 3;
  localparam int LANE_WORD_BITS = 21;

  // display link
  localparam int LANES = 3;
  localparam int SLOTS = 7;
  localparam logic [6:0] CLOCK_PATTERN = 7'h63;
  localparam logic [2:0] LAST_SLOT     = 3'h6;

  // lock qualification in frames
  localparam logic [2:0] LOCK_GOOD_FRAMES  = 3'h4;
  localparam logic [2:0] UNLOCK_BAD_FRAMES = 3'h2;

  // rates and analog settings, informational
  localparam int MAX_PIXEL_MHZ  = 43;
  localparam int MIN_LINE_MBPS  = 140;
  localparam int MAX_LINE_MBPS  = 1200;
  localparam int LOW_BAND_MHZ_MIN  = 5;
  localparam int LOW_BAND_MHZ_MAX  = 20;
  localparam int HIGH_BAND_MHZ_MIN = 20;
  localparam int HIGH_BAND_MHZ_MAX = 43;
  localparam int EQ_ON_GAIN_MDB    = 13000;
  localparam int EQ_OFF_GAIN_MDB   = 1625;
  localparam int SWING_LARGE_MV    = 400;
  localparam int SWING_SMALL_MV    = 250;

  // timing
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int LOSS_TIME_HIGH_NS = 10000;
  localparam int LOSS_TIME_LOW_NS  = 40000;
  localparam int STRAP_SETTLE_NS   = 100;
  localparam int LOSS_CYCLES_HIGH =
    (LOSS_TIME_HIGH_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOSS_CYCLES_LOW =
    (LOSS_TIME_LOW_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] STRAP_SETTLE_CYCLES =
    8'((STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [2:0] {
    HUNT   = 3'h1,
    CHECK  = 3'h2,
    LOCKED = 3'h4
  } svlr_lock_type;

  typedef enum logic [2:0] {
    SETTLE = 3'h1,
    SAMPLE = 3'h2,
    RUN    = 3'h4
  } svlr_strap_type;

endpackage

// [rtl/svlr_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module svlr_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // crossing
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = stage2 ~^ stage3;
  wire  [WIDTH-1:0] next_stable = (agree & stage2) | (~agree & stable);

  if (WIDTH < 1) begin : g_bad
    $error("svlr_sync needs WIDTH of at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage1 feeds only stage2
  always_ff @(posedge clk) begin
    stage1 <= async_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stable <= INIT;
    end else begin
      stable <= next_stable;
    end
  end

endmodule

`default_nettype wire

// [rtl/svlr_receiver.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Colour, both syncs and enable are recovered from one serial line and put on the display link.
// - The display link is three data lanes plus one clock lane.
// - Pixel rates up to 43 MHz from a 140 Mbps to 1.2 Gbps line are served.
// - Lock is found on arbitrary data without training pattern or reference.
// - A DC balanced line code is decoded back into the original payload.
// - Three slow outputs copy the far side inputs, which it keeps below a fifth of the pixel rate.
// - While recovery is locked the lock output is high and the outputs are active.
// - While unlocked the lock output is low and outputs take the chosen sleep state.
// - Power-down low resets all control state and puts outputs in their set state.
// - The output enable pin drives the display link when high and floats it when low.
// - Low rate select, by pin or by register, picks the 5-20 MHz or 20-43 MHz band.
// - The strap on the shared pin is sampled at power-up and held as equalizer setting.
// - Strap high turns about 13 dB equalizer gain on, low leaves about 1.625 dB.
// - Swing select high picks the 400 mV swing and low the 250 mV swing.
// - A three bit input picks the spread spectrum setting of the output clock.
// - After sampling, the shared pin reports self-test pass high and fail low.
module svlr_receiver #(
  parameter int LOSS_CYCLES_HIGH = svlr_pkg::LOSS_CYCLES_HIGH,
  parameter int LOSS_CYCLES_LOW  = svlr_pkg::LOSS_CYCLES_LOW
) (
  // system clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // serial link
  input  wire logic       LINK_CLK,
  input  wire logic       SERIAL_LINE_IN,
  // configuration pins
  input  wire logic       POWER_DOWN_N,
  input  wire logic       OUTPUT_ENABLE_IN,
  input  wire logic       SLEEP_STATE_SELECT,
  input  wire logic       LOW_RATE_SELECT,
  input  wire logic       SWING_SELECT,
  input  wire logic [2:0] SPREAD_RANGE_SELECT,
  input  wire logic       SELF_TEST_EN,
  // low rate register from local logic
  input  wire logic       LOW_RATE_REG_EN,
  input  wire logic       LOW_RATE_REG_VAL,
  // shared strap and pass pin
  input  wire logic       STRAP_PIN_IN,
  output logic            STRAP_PIN_OUT,
  output logic            STRAP_PIN_OE,
  // display link
  output logic [2:0]      LANE_DATA_OUT,
  output logic [2:0]      LANE_DATA_OE,
  output logic            LANE_CLOCK_OUT,
  output logic            LANE_CLOCK_OE,
  // status and settings
  output logic [2:0]      SLOW_SIDE_OUT,
  output logic            LINK_LOCKED,
  output logic            LOW_RATE_ACTIVE,
  output logic            EQUALIZER_STRAP,
  output logic            SWING_LARGE,
  output logic [2:0]      SPREAD_SETTING
);

  localparam int FB = svlr_pkg::FRAME_BITS;
  localparam int PB = svlr_pkg::PAYLOAD_BITS;
  localparam int LW = svlr_pkg::LANE_WORD_BITS;

  if (LOSS_CYCLES_HIGH < 1 || LOSS_CYCLES_HIGH > 65535 ||
      LOSS_CYCLES_LOW < 1 || LOSS_CYCLES_LOW > 65535) begin : g_bad
    $error("svlr_receiver loss counts must fit sixteen bits");
  end

  function automatic logic [6:0] lane_slice(input logic [LW-1:0] w,
                                            input int lane);
    lane_slice = w[lane*svlr_pkg::SLOTS +: svlr_pkg::SLOTS];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: crossing of the run level
  logic run;
  logic link_run;

  svlr_sync #(.WIDTH(1), .INIT(1'h0)) u_link_sync (
    .clk      (LINK_CLK),
    .rst_n    (1'h1),
    .async_in (run),
    .stable   (link_run)
  );

  wire link_rst = ~link_run;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: framing, lock hunt, line decode
  logic [FB-1:0]              shreg;
  logic [4:0]                 bitcnt;
  logic [2:0]                 good_cnt;
  logic [2:0]                 bad_cnt;
  svlr_pkg::svlr_lock_type    lock_state;
  logic [PB-1:0]              word_l;
  logic                       word_tgl;
  logic                       err_tgl;

  wire [FB-1:0] next_shreg = {shreg[FB-2:0], SERIAL_LINE_IN};
  wire boundary = bitcnt == 5'(FB - 1);
  wire frame_ok = next_shreg[svlr_pkg::START_POS] &
                  ~next_shreg[svlr_pkg::STOP_POS] &
                  ~next_shreg[svlr_pkg::SPARE_POS];
  // balance bit set means the payload went out inverted
  wire [PB-1:0] payload = next_shreg[svlr_pkg::PAYLOAD_LSB +: PB] ^
                          {PB{next_shreg[svlr_pkg::BALANCE_POS]}};
  // a bad boundary while hunting holds the count: one bit of slip
  wire slip = boundary & ~frame_ok &
              (lock_state == svlr_pkg::HUNT);
  wire publish = boundary & frame_ok &
                 (lock_state == svlr_pkg::LOCKED);
  wire bad_locked = boundary & ~frame_ok &
                    (lock_state == svlr_pkg::LOCKED);

  always_ff @(posedge LINK_CLK) begin
    shreg <= next_shreg;
    if (link_rst || (boundary && !slip)) begin
      bitcnt <= 5'h00;
    end else if (!boundary) begin
      bitcnt <= bitcnt + 5'h01;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      lock_state <= svlr_pkg::HUNT;
      good_cnt   <= 3'h0;
      bad_cnt    <= 3'h0;
    end else if (boundary) begin
      unique case (lock_state)
        svlr_pkg::HUNT: begin
          if (frame_ok) begin
            lock_state <= svlr_pkg::CHECK;
            good_cnt   <= 3'h1;
          end
        end
        svlr_pkg::CHECK: begin
          if (!frame_ok) begin
            lock_state <= svlr_pkg::HUNT;
          end else if (good_cnt == svlr_pkg::LOCK_GOOD_FRAMES - 3'h1) begin
            lock_state <= svlr_pkg::LOCKED;
            bad_cnt    <= 3'h0;
          end else begin
            good_cnt <= good_cnt + 3'h1;
          end
        end
        svlr_pkg::LOCKED: begin
          if (frame_ok) begin
            bad_cnt <= 3'h0;
          end else if (bad_cnt == svlr_pkg::UNLOCK_BAD_FRAMES - 3'h1) begin
            lock_state <= svlr_pkg::HUNT;
          end else begin
            bad_cnt <= bad_cnt + 3'h1;
          end
        end
      endcase
    end
  end

  // word stays put for a whole frame, far longer than the crossing
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      word_l   <= '0;
      word_tgl <= 1'h0;
      err_tgl  <= 1'h0;
    end else begin
      if (publish) begin
        word_l   <= payload;
        word_tgl <= ~word_tgl;
      end
      if (bad_locked) begin
        err_tgl <= ~err_tgl;
      end
    end
  end

  wire link_lock = lock_state == svlr_pkg::LOCKED;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: pin and link crossings
  logic [12:0] pins_s;

  svlr_sync #(.WIDTH(13), .INIT(13'h0000)) u_pin_sync (
    .clk      (CLK),
    .rst_n    (RSTN),
    .async_in ({err_tgl, word_tgl, link_lock, STRAP_PIN_IN, SELF_TEST_EN,
                SPREAD_RANGE_SELECT, SWING_SELECT, LOW_RATE_SELECT,
                SLEEP_STATE_SELECT, OUTPUT_ENABLE_IN, POWER_DOWN_N}),
    .stable   (pins_s)
  );

  wire       pd_n_s    = pins_s[0];
  wire       oe_s      = pins_s[1];
  wire       sleep_s   = pins_s[2];
  wire       low_s     = pins_s[3];
  wire       swing_s   = pins_s[4];
  wire [2:0] spread_s  = pins_s[7:5];
  wire       test_s    = pins_s[8];
  wire       strap_s   = pins_s[9];
  wire       lock_s    = pins_s[10];
  wire       word_t_s  = pins_s[11];
  wire       err_t_s   = pins_s[12];

  wire ctl_rst = ~RSTN | ~pd_n_s;

  always_ff @(posedge CLK) begin
    run <= ~ctl_rst;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: word arrival and lock
  logic          word_seen;
  logic          err_seen;
  logic [PB-1:0] word;
  logic [15:0]   idle_cnt;
  logic          locked;

  wire word_evt = word_t_s ^ word_seen;
  wire err_evt  = err_t_s ^ err_seen;
  wire low_rate_next = LOW_RATE_REG_EN ? LOW_RATE_REG_VAL : low_s;
  // a stopped link clock freezes the link side, so silence ends lock here
  wire [15:0] idle_limit = LOW_RATE_ACTIVE ? 16'(LOSS_CYCLES_LOW - 1) :
                                             16'(LOSS_CYCLES_HIGH - 1);
  wire idle_over = idle_cnt >= idle_limit;
  wire next_locked = lock_s & ~idle_over;

  always_ff @(posedge CLK) begin
    if (ctl_rst) begin
      word_seen <= 1'h0;
      err_seen  <= 1'h0;
      word      <= '0;
      idle_cnt  <= 16'h0000;
      locked    <= 1'h0;
    end else begin
      word_seen <= word_t_s;
      err_seen  <= err_t_s;
      if (word_evt) begin
        word <= word_l;
      end
      if (word_evt) begin
        idle_cnt <= 16'h0000;
      end else if (!idle_over) begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
      locked <= next_locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display link serializer, seven slots per pixel
  logic [2:0]    slot;
  logic [LW-1:0] pixel;
  logic [2:0]    lane_bit;
  logic          clk_bit;

  wire [LW-1:0] lane_word = {word[svlr_pkg::ENABLE_POS],
                             word[svlr_pkg::VSYNC_POS],
                             word[svlr_pkg::HSYNC_POS],
                             word[svlr_pkg::COLOUR_LSB +:
                                  svlr_pkg::COLOUR_BITS]};
  wire slot_wrap = slot == svlr_pkg::LAST_SLOT;
  // float when disabled; when unlocked, sleep select high floats too
  wire drive = oe_s & (locked | ~sleep_s);

  always_ff @(posedge CLK) begin
    if (ctl_rst) begin
      slot  <= 3'h0;
      pixel <= '0;
    end else begin
      slot <= slot_wrap ? 3'h0 : slot + 3'h1;
      if (slot_wrap) begin
        pixel <= lane_word;
      end
    end
  end

  for (genvar k = 0; k < svlr_pkg::LANES; k++) begin : g_lane
    wire [6:0] bits = lane_slice(pixel, k);
    always_ff @(posedge CLK) begin
      if (ctl_rst) begin
        lane_bit[k] <= 1'h0;
      end else begin
        lane_bit[k] <= locked & bits[slot];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (ctl_rst) begin
      clk_bit <= 1'h0;
    end else begin
      clk_bit <= locked & svlr_pkg::CLOCK_PATTERN[slot];
    end
  end

  assign LANE_DATA_OUT  = lane_bit;
  assign LANE_CLOCK_OUT = clk_bit;
  assign LANE_DATA_OE   = {svlr_pkg::LANES{drive}};
  assign LANE_CLOCK_OE  = drive;
  assign LINK_LOCKED    = locked;

  ////////////////////////////////////////////////////////////////////////////
  // settings and slow outputs
  always_ff @(posedge CLK) begin
    if (ctl_rst) begin
      SLOW_SIDE_OUT   <= 3'h0;
      LOW_RATE_ACTIVE <= 1'h0;
      SWING_LARGE     <= 1'h0;
      SPREAD_SETTING  <= 3'h0;
    end else begin
      if (word_evt) begin
        SLOW_SIDE_OUT <= word_l[svlr_pkg::SLOW_LSB +:
                                svlr_pkg::SLOW_BITS];
      end
      LOW_RATE_ACTIVE <= low_rate_next;
      SWING_LARGE     <= swing_s;
      SPREAD_SETTING  <= spread_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture and self-test report on the shared pin
  svlr_pkg::svlr_strap_type strap_state;
  logic [7:0]               settle_cnt;
  logic                     test_err;
  logic                     pass_bit;

  // clear beats set: with self-test off a late error is dropped
  wire next_test_err = (err_evt & test_s) | (test_err & test_s);

  always_ff @(posedge CLK) begin
    if (ctl_rst) begin
      strap_state     <= svlr_pkg::SETTLE;
      settle_cnt      <= 8'h00;
      EQUALIZER_STRAP <= 1'h0;
    end else begin
      unique case (strap_state)
        svlr_pkg::SETTLE: begin
          settle_cnt <= settle_cnt + 8'h01;
          if (settle_cnt == svlr_pkg::STRAP_SETTLE_CYCLES - 8'h01) begin
            strap_state <= svlr_pkg::SAMPLE;
          end
        end
        svlr_pkg::SAMPLE: begin
          EQUALIZER_STRAP <= strap_s;
          strap_state     <= svlr_pkg::RUN;
        end
        svlr_pkg::RUN: begin
          strap_state <= svlr_pkg::RUN;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (ctl_rst) begin
      test_err <= 1'h0;
      pass_bit <= 1'h0;
    end else begin
      test_err <= next_test_err;
      pass_bit <= ~next_test_err;
    end
  end

  assign STRAP_PIN_OUT = pass_bit;
  assign STRAP_PIN_OE  = (strap_state == svlr_pkg::RUN) & test_s;

endmodule

`default_nettype wire

// [tb/svlr_receiver_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module svlr_receiver_chk (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // pins
  input wire logic       POWER_DOWN_N,
  input wire logic       OUTPUT_ENABLE_IN,
  input wire logic       SLEEP_STATE_SELECT,
  input wire logic       SWING_SELECT,
  input wire logic [2:0] SPREAD_RANGE_SELECT,
  input wire logic       SELF_TEST_EN,
  input wire logic       LOW_RATE_REG_EN,
  input wire logic       LOW_RATE_REG_VAL,
  input wire logic       STRAP_PIN_IN,
  // outputs
  input wire logic       STRAP_PIN_OE,
  input wire logic [2:0] LANE_DATA_OUT,
  input wire logic [2:0] LANE_DATA_OE,
  input wire logic       LANE_CLOCK_OUT,
  input wire logic       LANE_CLOCK_OE,
  input wire logic [2:0] SLOW_SIDE_OUT,
  input wire logic       LINK_LOCKED,
  input wire logic       LOW_RATE_ACTIVE,
  input wire logic       EQUALIZER_STRAP,
  input wire logic       SWING_LARGE,
  input wire logic [2:0] SPREAD_SETTING
);
  // cycles since reset and power-down both let go, saturating
  logic [5:0] run_cnt;

  always_ff @(posedge CLK) begin
    if (RSTN && POWER_DOWN_N) begin
      run_cnt <= run_cnt + {5'h0, run_cnt != 6'h3f};
    end else begin
      run_cnt <= 6'h0;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  ////////////////////////////////////////////////////////////////////////////
  oe_off_a: assert property (
    (!OUTPUT_ENABLE_IN)[*7] |-> LANE_DATA_OE == 3'h0 && !LANE_CLOCK_OE)
    else $error("display link driven with enable low");
  lock_drive_a: assert property (
    (LINK_LOCKED && OUTPUT_ENABLE_IN)[*7] |-> LANE_DATA_OE == 3'h7)
    else $error("display link idle while locked");
  sleep_float_a: assert property (
    (!LINK_LOCKED && SLEEP_STATE_SELECT)[*7] |-> !LANE_CLOCK_OE)
    else $error("display link driven in floating sleep");
  unlocked_low_a: assert property (
    (!LINK_LOCKED)[*3] |-> LANE_DATA_OUT == 3'h0 && !LANE_CLOCK_OUT)
    else $error("display link active while unlocked");
  pd_reset_a: assert property (
    (!POWER_DOWN_N)[*7] |-> !LINK_LOCKED && !STRAP_PIN_OE &&
    SLOW_SIDE_OUT == 3'h0 && !EQUALIZER_STRAP)
    else $error("state kept through power-down");
  selftest_oe_a: assert property (
    (!SELF_TEST_EN)[*7] |-> !STRAP_PIN_OE)
    else $error("shared pin driven outside self-test");
  strap_take_a: assert property (
    run_cnt == 6'h1e |-> EQUALIZER_STRAP == STRAP_PIN_IN)
    else $error("strap level not latched");
  strap_hold_a: assert property (
    run_cnt >= 6'h28 |-> $stable(EQUALIZER_STRAP))
    else $error("latched strap changed");
  rate_reg_a: assert property (
    run_cnt >= 6'hc && LOW_RATE_REG_EN |=>
    LOW_RATE_ACTIVE == $past(LOW_RATE_REG_VAL))
    else $error("rate register not followed");
  setting_follow_a: assert property (
    (run_cnt >= 6'hc && $stable(SWING_SELECT) &&
    $stable(SPREAD_RANGE_SELECT))[*8] |-> SWING_LARGE == SWING_SELECT &&
    SPREAD_SETTING == SPREAD_RANGE_SELECT)
    else $error("swing or spread not followed");
endmodule

bind svlr_receiver svlr_receiver_chk u_svlr_receiver_chk (.*);

`default_nettype wire

// [tb/svlr_serializer.sv]
`timescale 1ns/1ps
`default_nettype none

module svlr_serializer (
  // control
  input  wire logic        link_clk,
  input  wire logic        send,
  input  wire logic        corrupt,
  input  wire logic [23:0] payload,
  // serial side
  output logic             line,
  output logic             frame_ld
);
  logic [27:0] shift = 28'h0;
  logic [4:0]  bit_cnt = 5'h0;
  logic        balance;
  logic [27:0] frame;

  // heavy words go inverted so the coupled line keeps no dc
  assign balance = $countones(payload) > 12;
  // no training: plain frames from the first bit, bad stop on request
  assign frame = {1'b1, balance ? ~payload : payload, balance, 1'b0,
                  corrupt};
  assign line = shift[27];

  always_ff @(posedge link_clk) begin
    frame_ld <= send && bit_cnt == 5'h0;
    if (!send) begin
      shift   <= {~shift[27], 27'h0};
      bit_cnt <= 5'h0;
    end else begin
      shift   <= (bit_cnt == 5'h0) ? frame : {shift[26:0], 1'b0};
      bit_cnt <= (bit_cnt == 5'h1b) ? 5'h0 : bit_cnt + 5'h1;
    end
  end
endmodule

`default_nettype wire

// [tb/svlr_receiver_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module svlr_receiver_tb;
  // swing, spread, rate pin, reg en, reg val | swing, spread, rate
  localparam logic [11:0] ROWS [8] = '{12'h081, 12'h932, 12'h265, 12'hbd6,
                                       12'h489, 12'hd1a, 12'h66d, 12'hfbf};
  logic        clk, rstn, link_clk, ser_line, pd_n, oe_in, sleep_sel;
  logic        lf_sel, swing, st_en, reg_en, reg_val, strap_pull;
  logic        corrupt, send, frame_ld, clk_out, clk_oe, strap_out;
  logic        strap_oe, locked, low_act, eq_strap, swing_lg;
  logic [2:0]  spread, data_out, data_oe, slow_out, spread_set;
  logic [23:0] payload;
  wire logic   strap_wire;
  int          mismatches = 0;
  int          cmp_count = 0;

  // the strap resistor loses to the pass driver
  assign strap_wire = strap_oe ? strap_out : strap_pull;

  svlr_receiver #(.LOSS_CYCLES_HIGH(2000), .LOSS_CYCLES_LOW(4000))
  u_svlr_receiver (
    .CLK(clk), .RSTN(rstn), .LINK_CLK(link_clk), .SERIAL_LINE_IN(ser_line),
    .POWER_DOWN_N(pd_n), .OUTPUT_ENABLE_IN(oe_in),
    .SLEEP_STATE_SELECT(sleep_sel), .LOW_RATE_SELECT(lf_sel),
    .SWING_SELECT(swing), .SPREAD_RANGE_SELECT(spread), .SELF_TEST_EN(st_en),
    .LOW_RATE_REG_EN(reg_en), .LOW_RATE_REG_VAL(reg_val),
    .STRAP_PIN_IN(strap_wire), .STRAP_PIN_OUT(strap_out),
    .STRAP_PIN_OE(strap_oe), .LANE_DATA_OUT(data_out), .LANE_DATA_OE(data_oe),
    .LANE_CLOCK_OUT(clk_out), .LANE_CLOCK_OE(clk_oe), .SLOW_SIDE_OUT(slow_out),
    .LINK_LOCKED(locked), .LOW_RATE_ACTIVE(low_act),
    .EQUALIZER_STRAP(eq_strap), .SWING_LARGE(swing_lg),
    .SPREAD_SETTING(spread_set));

  svlr_serializer u_svlr_serializer (
    .link_clk(link_clk), .send(send), .corrupt(corrupt), .payload(payload),
    .line(ser_line), .frame_ld(frame_ld));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // odd start offset keeps the two clocks unrelated
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_lock(input logic exp, input int limit);
    int n;
    n = 0;
    while (locked !== exp && n < limit) begin
      step(1);
      n++;
    end
    check("link_locked", locked, exp);
    if (locked !== exp) close_out();
  endtask

  // stop bit of n whole frames set, starting at a frame boundary
  task automatic bad_frames(input int n);
    @(posedge frame_ld);
    corrupt = 1'b1;
    repeat (n) @(posedge frame_ld);
    corrupt = 1'b0;
    step(1);
  endtask

  task automatic check_lanes(input logic [23:0] p);
    int n;
    int s;
    n = 0;
    // clock lane rises only into slot 5
    while (clk_out !== 1'b0 && n < 20) begin step(1); n++; end
    while (clk_out !== 1'b1 && n < 20) begin step(1); n++; end
    check("slot align", n < 20, 1'b1);
    if (n >= 20) close_out();
    for (int i = 0; i < 7; i++) begin
      s = (5 + i) % 7;
      check("clock lane", clk_out, svlr_pkg::CLOCK_PATTERN[s]);
      check("data lanes", data_out, {p[14+s], p[7+s], p[s]});
      step(1);
    end
    check("slow side", slow_out, p[23:21]);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    check("watchdog", 1'b1, 1'b0);
    close_out();
  end

  initial begin
    {rstn, pd_n, oe_in, sleep_sel, lf_sel, swing, spread} = 9'h0c0;
    {st_en, reg_en, reg_val, strap_pull, corrupt, send} = 6'h04;
    payload = 24'hb5a3c7;
    step(20);
    rstn = 1'b1;
    step(40);
    check("eq strap", eq_strap, 1'b1);
    strap_pull = 1'b0;
    step(30);
    check("eq strap held", eq_strap, 1'b1);
    for (int i = 0; i < 8; i++) begin
      {swing, spread, lf_sel, reg_en, reg_val} = ROWS[i][11:5];
      step(10);
      check("swing", swing_lg, ROWS[i][4]);
      check("spread", spread_set, ROWS[i][3:1]);
      check("low rate", low_act, ROWS[i][0]);
    end
    {lf_sel, reg_en} = 2'h0;
    send = 1'b1;
    wait_lock(1'b1, 8000);
    check("lane oe", {data_oe, clk_oe}, 4'hf);
    step(1000);
    check_lanes(payload);
    payload = 24'h2c0183;
    step(3000);
    check_lanes(payload);
    oe_in = 1'b0;
    step(8);
    check("lane oe off", {data_oe, clk_oe}, 4'h0);
    oe_in = 1'b1;
    st_en = 1'b1;
    step(10);
    check("pass pin", {strap_oe, strap_out}, 2'h3);
    bad_frames(1);
    step(1200);
    check("pass error", {locked, strap_oe, strap_out}, 3'h6);
    st_en = 1'b0;
    step(10);
    check("pass off", strap_oe, 1'b0);
    bad_frames(2);
    wait_lock(1'b0, 1500);
    step(2);
    check("sleep low", {data_oe, clk_oe, data_out, clk_out}, 8'hf0);
    sleep_sel = 1'b1;
    step(8);
    check("sleep float", {data_oe, clk_oe}, 4'h0);
    sleep_sel = 1'b0;
    wait_lock(1'b1, 8000);
    pd_n = 1'b0;
    strap_pull = 1'b1;
    step(10);
    check("power down", {locked, slow_out, eq_strap}, 5'h0);
    pd_n = 1'b1;
    step(40);
    check("eq strap again", eq_strap, 1'b1);
    wait_lock(1'b1, 8000);
    close_out();
  end
endmodule

`default_nettype wire
